// >>> hpi_regs.vh
// Constants for the host-port interface block
`ifndef HPI_REGS_VH
`define HPI_REGS_VH
`define HPI_SEL_CTRL     2'h0
`define HPI_SEL_ADDR_INC 2'h1
`define HPI_SEL_ADDR     2'h2
`define HPI_SEL_DATA     2'h3
`define HPI_CTRL_INT_BIT 3
`define HPI_CTRL_DEV_BIT 2
`define HPI_CTRL_RST     16'h0000
`define HPI_ADDR_RST     18'h00000
`define HPI_RDY_WAIT     2'h2
`endif

// >>> hpi_port.v
// Host-port interface: pin-level strobe decode, registers and memory handshake
// Overview of operation
// - Two select inputs choose control, address or data register, in multiplexed mode.
// - Address strobe captures shared-line address into address register in multiplexed mode.
// - Direction input chooses whether device drives data out or accepts it.
// - Ready output shows device can take next transfer; host waits for it.
// - Host interrupt is driven low; host clears it writing 1 to control bit.
// - Host interrupt used only in multiplexed mode, never in nonmultiplexed mode.
// - Port reset input resets port logic and both processor subsystems.
// - Pins act as host port only while interface select is low.
// - Output-off low puts all port outputs, ready and interrupt, in high impedance.
// - Mode low multiplexed with interrupts; high nonmultiplexed 18-bit address, 16-bit data.
`include "hpi_regs.vh"
module hpi_port #(
	parameter AW = 18,
	parameter DW = 16
)(
	input  wire          i_ref_clk,
	input  wire          i_rst,
	input  wire          i_port_reset_in_n,
	input  wire          i_interface_select,
	input  wire          i_output_off_n,
	input  wire          i_mux_mode_select,
	input  wire          i_host_reg_select_bit0,
	input  wire          i_host_reg_select_bit1,
	input  wire          i_addr_strobe_n,
	input  wire          i_port_chip_select_n,
	input  wire          i_data_strobe_one_n,
	input  wire          i_data_strobe_two_n,
	input  wire          i_transfer_direction,
	input  wire [AW-1:0] i_host_addr,
	input  wire [DW-1:0] i_host_data,
	input  wire          i_dev_int_req,
	input  wire          i_mem_ack,
	input  wire [DW-1:0] i_mem_rdata,
	output reg  [DW-1:0] o_host_data,
	output reg           o_host_data_oe,
	output reg           o_port_ready_out,
	output reg           o_port_ready_oe,
	output reg           o_host_interrupt_n,
	output reg           o_host_interrupt_oe,
	output reg           o_subsys_reset,
	output reg           o_host_to_dev_int,
	output reg           o_mem_req,
	output reg           o_mem_we,
	output reg  [AW-1:0] o_mem_addr,
	output reg  [DW-1:0] o_mem_wdata
);
	localparam ST_IDLE = 2'h0;
	localparam ST_MEM  = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [1:0]    state_q;
	reg [DW-1:0] ctrl_q;
	reg [AW-1:0] addr_q;
	reg [DW-1:0] rdata_q;
	reg          strobe_q;
	reg          as_q;
	reg          int_q;
	reg          incr_q;
	reg [1:0]    wait_q;

	////////////////////////////////////////////////////////////////////////
	// Decode
	// Port active only
	wire port_on = ~i_interface_select;
	// Combined data strobe; either strobe low times a transfer
	wire strobe = ~i_data_strobe_one_n | ~i_data_strobe_two_n;
	wire access = port_on & ~i_port_chip_select_n & strobe;
	wire start  = access & ~strobe_q;
	wire finish = ~access & strobe_q;
	wire mux    = ~i_mux_mode_select;
	wire [1:0] sel = {i_host_reg_select_bit1, i_host_reg_select_bit0};

	// Register select; nonmultiplexed always hits data
	function [1:0] reg_of;
		input [1:0] s;
		input       m;
		begin
			if (!m)
				reg_of = `HPI_SEL_DATA;
			else if (s == `HPI_SEL_CTRL || s == `HPI_SEL_ADDR)
				reg_of = s;
			else
				reg_of = `HPI_SEL_DATA;
		end
	endfunction

	wire [1:0] tgt = reg_of(sel, mux);
	wire [AW-1:0] xfer_addr = mux ? addr_q : i_host_addr;

	////////////////////////////////////////////////////////////////////////
	// Sequencing; host port reset also clears the port logic
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q  <= ST_IDLE;
			ctrl_q   <= `HPI_CTRL_RST;
			addr_q   <= `HPI_ADDR_RST;
			rdata_q  <= {DW{1'b0}};
			strobe_q <= 1'b0;
			as_q     <= 1'b0;
			int_q    <= 1'b0;
			incr_q   <= 1'b0;
			wait_q   <= 2'h0;
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= `HPI_ADDR_RST;
			o_mem_wdata <= {DW{1'b0}};
			o_host_to_dev_int <= 1'b0;
		end
		else if (!i_port_reset_in_n)
		begin
			state_q  <= ST_IDLE;
			ctrl_q   <= `HPI_CTRL_RST;
			addr_q   <= `HPI_ADDR_RST;
			strobe_q <= 1'b0;
			as_q     <= 1'b0;
			int_q    <= 1'b0;
			o_mem_req <= 1'b0;
			o_host_to_dev_int <= 1'b0;
		end
		else
		begin
			strobe_q <= access;
			as_q     <= ~i_addr_strobe_n & port_on;
			o_host_to_dev_int <= 1'b0;
			if (port_on && mux && !i_addr_strobe_n && !as_q)
				addr_q <= i_host_addr;
			// Device event sets; set wins over host clear
			if (i_dev_int_req)
				int_q <= 1'b1;
			else if (start && tgt == `HPI_SEL_CTRL && !i_transfer_direction
				&& i_host_data[`HPI_CTRL_INT_BIT])
				int_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (start)
					begin
						case (tgt)
							`HPI_SEL_CTRL:
							begin
								if (!i_transfer_direction)
								begin
									ctrl_q <= i_host_data;
									o_host_to_dev_int <= i_host_data[`HPI_CTRL_DEV_BIT] & mux;
								end
								rdata_q <= {ctrl_q[DW-1:`HPI_CTRL_INT_BIT+1], int_q,
									ctrl_q[`HPI_CTRL_INT_BIT-1:0]};
								state_q <= ST_DONE;
							end
							`HPI_SEL_ADDR:
							begin
								if (!i_transfer_direction)
									addr_q <= {{(AW-DW){1'b0}}, i_host_data};
								rdata_q <= addr_q[DW-1:0];
								state_q <= ST_DONE;
							end
							default:
							begin
								o_mem_req   <= 1'b1;
								o_mem_we    <= ~i_transfer_direction;
								o_mem_addr  <= xfer_addr;
								o_mem_wdata <= i_host_data;
								incr_q      <= mux;
								state_q     <= ST_MEM;
							end
						endcase
						wait_q <= `HPI_RDY_WAIT;
					end
				end
				ST_MEM:
				begin
					if (i_mem_ack)
					begin
						o_mem_req <= 1'b0;
						rdata_q   <= i_mem_rdata;
						// Auto-advance keeps streaming hosts from rewriting the address
						if (incr_q)
							addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
						state_q <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					if (wait_q != 2'h0)
						wait_q <= wait_q - 2'h1;
					// Hold ready low a few cycles so a fast host cannot restart too early
					if ((finish || !access) && wait_q == 2'h0)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, all registered
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_host_data         <= {DW{1'b0}};
			o_host_data_oe      <= 1'b0;
			o_port_ready_out    <= 1'b0;
			o_port_ready_oe     <= 1'b0;
			o_host_interrupt_n  <= 1'b1;
			o_host_interrupt_oe <= 1'b0;
			o_subsys_reset      <= 1'b1;
		end
		else
		begin
			o_subsys_reset   <= ~i_port_reset_in_n;
			o_host_data      <= rdata_q;
			o_host_data_oe   <= i_output_off_n & port_on & access & i_transfer_direction
				& (state_q == ST_DONE);
			// Ready only when idle; drops on the start edge itself
			o_port_ready_out <= (state_q == ST_IDLE) & ~start & i_port_reset_in_n;
			o_port_ready_oe  <= i_output_off_n & port_on;
			o_host_interrupt_n  <= ~(int_q & mux);
			o_host_interrupt_oe <= i_output_off_n & port_on & mux;
		end
	end
endmodule

// >>> hpi_mem_model.sv
// Memory model answering the port's requests
module hpi_mem_model (
	input  wire         i_ref_clk,
	input  wire         i_req,
	input  wire         i_we,
	input  wire  [3:0]  i_addr,
	input  wire  [15:0] i_wdata,
	output logic        o_ack   = 1'b0,
	output logic [15:0] o_rdata = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [16];
	logic [1:0]  cnt_q = 2'h0;
	// Answer after a wait so ready is seen low; rdata toggles when idle
	always @(posedge i_ref_clk)
	begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		cnt_q <= (i_req && !o_ack) ? cnt_q + 2'h1 : 2'h0;
		if (i_req && !o_ack && cnt_q == 2'h1)
		begin
			o_ack <= 1'b1;
			o_rdata <= mem[i_addr];
			if (i_we)
				mem[i_addr] <= i_wdata;
		end
	end
endmodule

// >>> hpi_port_monitor.sv
// Concurrent checks on the host-port pins
module hpi_port_monitor (
	input wire i_ref_clk,
	input wire i_rst,
	input wire i_port_reset_in_n,
	input wire i_interface_select,
	input wire i_output_off_n,
	input wire i_mux_mode_select,
	input wire i_dev_int_req,
	input wire i_mem_ack,
	input wire o_host_data_oe,
	input wire o_port_ready_out,
	input wire o_port_ready_oe,
	input wire o_host_interrupt_n,
	input wire o_host_interrupt_oe,
	input wire o_subsys_reset,
	input wire o_host_to_dev_int,
	input wire o_mem_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	a_off_tristate: assert property (!i_output_off_n |=> !o_port_ready_oe && !o_host_interrupt_oe && !o_host_data_oe)
		else $error("driving while off");
	a_int_mux_only: assert property (i_mux_mode_select |=> !o_host_interrupt_oe)
		else $error("interrupt driven in nonmux");
	a_subsys_reset: assert property (!i_port_reset_in_n |=> o_subsys_reset)
		else $error("subsystem reset missing");
	a_req_hold: assert property (o_mem_req && !i_mem_ack && i_port_reset_in_n |=> o_mem_req)
		else $error("request dropped");
	a_ready_busy: assert property (o_mem_req |-> !o_port_ready_out)
		else $error("ready while busy");
	a_select_no_oe: assert property (i_interface_select [*3] |-> !o_host_data_oe)
		else $error("data driven off port");
	a_int_raised: assert property (i_dev_int_req && !i_mux_mode_select && i_port_reset_in_n |-> ##[1:2] !o_host_interrupt_n)
		else $error("interrupt not raised");
	a_ready_boot: assert property ($fell(i_rst) && i_port_reset_in_n |=> o_port_ready_out)
		else $error("not ready after reset");
	a_dev_int_pulse: assert property (o_host_to_dev_int |=> !o_host_to_dev_int)
		else $error("host-to-device interrupt longer than one cycle");
	a_dev_int_nonmux: assert property (i_mux_mode_select |=> !o_host_to_dev_int)
		else $error("host-to-device interrupt in nonmux");
	c_dev_int: cover property (o_host_to_dev_int);
	c_mem_ack: cover property (o_mem_req && i_mem_ack);
	c_int: cover property (!o_host_interrupt_n);
	c_read: cover property (o_host_data_oe);
endmodule
bind hpi_port hpi_port_monitor i_hpi_port_monitor (.*);

// >>> testbench.sv
// Self-checking bench for the host port
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 0, i_rst = 1, i_port_reset_in_n = 1, i_interface_select = 0, i_output_off_n = 1;
	logic i_mux_mode_select = 0, i_host_reg_select_bit0 = 0, i_host_reg_select_bit1 = 0, i_addr_strobe_n = 1;
	logic i_port_chip_select_n = 1, i_data_strobe_one_n = 1, i_data_strobe_two_n = 1, i_transfer_direction = 0;
	logic i_dev_int_req = 0, i_mem_ack, o_host_data_oe, o_port_ready_out, o_port_ready_oe, o_host_interrupt_n;
	logic o_host_interrupt_oe, o_subsys_reset, o_host_to_dev_int, o_mem_req, o_mem_we;
	logic [17:0] i_host_addr = 18'h00000, o_mem_addr;
	logic [15:0] i_host_data = 16'h0000, i_mem_rdata, o_host_data, o_mem_wdata;
	int num_errors = 0, compares = 0;
	logic dev_int_seen = 0;
	hpi_port i_hpi_port (.*);
	hpi_mem_model i_hpi_mem_model (.i_ref_clk(i_ref_clk), .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr[3:0]), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	initial
		forever #25 i_ref_clk = ~i_ref_clk;
	// Sticky copy of the one-cycle host-to-device pulse
	always @(posedge i_ref_clk)
		if (o_host_to_dev_int === 1'b1)
			dev_int_seen <= 1'b1;
	task automatic chk(input string n, input logic [15:0] e, g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// One transfer; d is write data, or the expected read data
	task automatic acc(input logic [1:0] s, input logic r, input logic [15:0] d);
		for (int i = 0; i < 20 && o_port_ready_out !== 1'b1; i++)
			@(posedge i_ref_clk);
		chk("ready_wait", 16'h0001, o_port_ready_out);
		@(posedge i_ref_clk);
		{i_host_reg_select_bit1, i_host_reg_select_bit0} <= s;
		i_transfer_direction <= r;
		i_host_data <= d;
		i_port_chip_select_n <= 1'b0;
		i_data_strobe_one_n <= r;
		i_data_strobe_two_n <= !r;
		repeat (8) @(posedge i_ref_clk);
		if (r)
		begin
			chk("host_data", d, o_host_data);
			chk("host_data_oe", 16'h0001, o_host_data_oe);
		end
		i_data_strobe_one_n <= 1'b1;
		i_data_strobe_two_n <= 1'b1;
	endtask
	task automatic final_report;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// About 8 us of tests; give a hang about twelve times that
	initial
	begin
		#100us;
		num_errors++;
		final_report;
	end
	initial
	begin
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		chk("ready", 16'h0001, o_port_ready_out);
		acc(2'h2, 0, 16'h0005);
		acc(2'h3, 0, 16'hA5A5);
		acc(2'h1, 0, 16'h5A5A);
		acc(2'h2, 0, 16'h0005);
		acc(2'h3, 1, 16'hA5A5);
		acc(2'h1, 1, 16'h5A5A);
		acc(2'h2, 1, 16'h0007);
		i_host_addr <= 18'h00006;
		i_addr_strobe_n <= 1'b0;
		@(posedge i_ref_clk);
		i_addr_strobe_n <= 1'b1;
		acc(2'h3, 1, 16'h5A5A);
		$display("transfers done");
		i_dev_int_req <= 1'b1;
		@(posedge i_ref_clk);
		i_dev_int_req <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		chk("int_n", 16'h0000, o_host_interrupt_n);
		acc(2'h0, 1, 16'h0008);
		acc(2'h0, 0, 16'h0008);
		repeat (3) @(posedge i_ref_clk);
		chk("int_n", 16'h0001, o_host_interrupt_n);
		chk("dev_int", 16'h0000, dev_int_seen);
		acc(2'h0, 0, 16'h0004);
		chk("dev_int", 16'h0001, dev_int_seen);
		i_mux_mode_select <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		chk("int_oe", 16'h0000, o_host_interrupt_oe);
		i_mux_mode_select <= 1'b0;
		$display("interrupt done");
		i_output_off_n <= 1'b0;
		i_interface_select <= 1'b1;
		i_port_reset_in_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		chk("ready_oe", 16'h0000, o_port_ready_oe);
		chk("subsys_rst", 16'h0001, o_subsys_reset);
		i_output_off_n <= 1'b1;
		i_interface_select <= 1'b0;
		i_port_reset_in_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		acc(2'h2, 1, 16'h0000);
		$display("reset done");
		final_report;
	end
endmodule
